/* include/core_exec_pkg.sv */
/*
  Package for the instruction decode and execute block: instruction
  field positions, opcode patterns, flag positions, reset values and
  the instruction-cycle timing constants.
  Assumes a single 125 MHz clock.
*/
package core_exec_pkg;

  // ----------------------------------------------------------------
  // Word and field layout
  // ----------------------------------------------------------------
  localparam int INSTR_W      = 14;
  localparam int DATA_W       = 8;
  localparam int FILE_ADDR_W  = 7;
  localparam int BIT_SEL_W    = 3;
  localparam int LIT8_W       = 8;
  localparam int LIT11_W      = 11;
  localparam int PC_W         = 13;
  localparam int LATCH_W      = 5;
  localparam int DEST_BIT     = 7;
  localparam int BIT_SEL_LSB  = 7;
  localparam int LATCH_HI     = 4;
  localparam int LATCH_LO     = 3;
  localparam int FILE_MAX     = 8'h7F;

  // ----------------------------------------------------------------
  // Opcode patterns (don't-care bits masked out)
  // ----------------------------------------------------------------
  localparam logic [13:0] MASK_OR_ACCUM  = 14'h3F00;
  localparam logic [13:0] PAT_OR_ACCUM   = 14'h0400;
  localparam logic [13:0] MASK_SKIP_SET  = 14'h3C00;
  localparam logic [13:0] PAT_SKIP_SET   = 14'h1C00;
  localparam logic [13:0] MASK_CALL      = 14'h3800;
  localparam logic [13:0] PAT_CALL       = 14'h2000;
  localparam logic [13:0] MASK_LOAD_LIT  = 14'h3C00;
  localparam logic [13:0] PAT_LOAD_LIT   = 14'h3000;

  // ----------------------------------------------------------------
  // Status flags and reset values
  // ----------------------------------------------------------------
  localparam int FLAG_CARRY   = 0;
  localparam int FLAG_DIGIT   = 1;
  localparam int FLAG_ZERO    = 2;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [7:0] ACCUM_RESET  = 8'h00;
  localparam logic [12:0] PC_RESET    = 13'h0000;

  // ----------------------------------------------------------------
  // Timing: oscillator periods per instruction cycle
  // ----------------------------------------------------------------
  localparam int QUARTERS        = 4;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int OSC_PERIOD_NS   = 8;
  localparam int CLKS_PER_QUARTER =
    (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* design/quarter_phase_gen.sv */
/*
  Quarter-phase generator: divides the clock into oscillator periods
  and counts four of them to one instruction cycle.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module quarter_phase_gen #(
  parameter int CLKS_PER_QUARTER = core_exec_pkg::CLKS_PER_QUARTER
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  output logic      [1:0] quarter,
  output logic            quarter_tick,
  output logic            cycle_end
);

  localparam int DIV_W = (CLKS_PER_QUARTER > 1) ? $clog2(CLKS_PER_QUARTER) : 1;

  logic [DIV_W-1:0] div_count;

  if (CLKS_PER_QUARTER < 1)
  begin : g_bad_div
    $error("quarter_phase_gen: CLKS_PER_QUARTER must be at least 1");
  end

  assign quarter_tick = (div_count == DIV_W'(CLKS_PER_QUARTER - 1));
  assign cycle_end    = quarter_tick && (quarter == 2'h3);

  // ----------------------------------------------------------------
  // Oscillator-period divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      div_count <= '0;
    else if (quarter_tick)
      div_count <= '0;
    else
      div_count <= div_count + DIV_W'(1);
  end

  // ----------------------------------------------------------------
  // Four quarters per instruction cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      quarter <= 2'h0;
    else if (quarter_tick)
      quarter <= quarter + 2'h1;
  end

endmodule

/* design/instr_exec.sv */
/*
  Instruction decode and execute for a small 8-bit core. Splits each
  14-bit word into fields, runs it over four quarters, writes the
  result to the accumulator or a file register, and inserts an idle
  cycle after a taken skip or a call.
  Assumes program memory presents instr_word for the whole cycle and
  the register file answers file_rdata combinationally from file_addr.
*/
`timescale 1ns/1ps
// Contract
// RULE_01: Every instruction is one 14-bit word
// RULE_02: Destination bit zero writes accumulator, else file
// RULE_03: File address field is 7 bits
// RULE_04: Three-bit field selects bit of register
// RULE_05: Literals are 8 bits, targets 11 bits
// RULE_06: One cycle; two when skipping or branching
// RULE_07: Instruction cycle is four oscillator periods
// RULE_08: Don't-care bits never change execution
// RULE_09: Skip-if-bit-set discards next when bit one
// RULE_10: Call pushes return, loads target and latch
// RULE_11: OR accumulator with file, update zero
// RULE_12: Load literal to accumulator, flags unchanged
// RULE_13: Only defined flags change in status
// RULE_14: Accumulator is internal, never file-addressed
// RULE_15: Decode, read, process, write by quarter
// RULE_16: Idle cycle suppresses all writes
module instr_exec #(
  parameter int CLKS_PER_QUARTER = core_exec_pkg::CLKS_PER_QUARTER
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [13:0] instr_word,
  input  wire logic [4:0]  program_counter_upper_latch,
  input  wire logic [7:0]  file_rdata,
  output logic      [6:0]  file_addr,
  output logic      [7:0]  file_wdata,
  output logic             file_we,
  output logic      [12:0] program_counter,
  output logic      [12:0] stack_top_entry,
  output logic             stack_push,
  output logic      [7:0]  accum,
  output logic      [2:0]  status_flags,
  output logic             idle_cycle,
  output logic      [1:0]  quarter,
  output logic             cycle_end
);

  typedef enum logic [2:0] {
    OP_OTHER,
    OP_OR_ACCUM,
    OP_SKIP_SET,
    OP_CALL,
    OP_LOAD_LIT
  } op_t;

  if (CLKS_PER_QUARTER < 1)
  begin : g_bad_div
    $error("instr_exec: CLKS_PER_QUARTER must be at least 1");
  end

  // ----------------------------------------------------------------
  // Quarter timing
  // ----------------------------------------------------------------
  logic quarter_tick;

  quarter_phase_gen #(
    .CLKS_PER_QUARTER (CLKS_PER_QUARTER)
  ) u_phase (
    .clk          (clk),
    .reset_n      (reset_n),
    .quarter      (quarter),
    .quarter_tick (quarter_tick),
    .cycle_end    (cycle_end)
  ); // [RULE_07]

  wire q1_end = quarter_tick && (quarter == 2'h0);
  wire q2_end = quarter_tick && (quarter == 2'h1);
  wire q3_end = quarter_tick && (quarter == 2'h2);

  // ----------------------------------------------------------------
  // Field split
  // ----------------------------------------------------------------
  logic [13:0] instr;
  op_t         op;
  logic        dest_file;
  logic [6:0]  f_field;
  logic [2:0]  bit_sel;
  logic [7:0]  lit8;
  logic [10:0] lit11;

  assign dest_file = instr[core_exec_pkg::DEST_BIT]; // [RULE_02]
  assign f_field   = instr[core_exec_pkg::FILE_ADDR_W-1:0]; // [RULE_03]
  assign bit_sel   = instr[core_exec_pkg::BIT_SEL_LSB +: core_exec_pkg::BIT_SEL_W]; // [RULE_04]
  assign lit8      = instr[core_exec_pkg::LIT8_W-1:0]; // [RULE_05]
  assign lit11     = instr[core_exec_pkg::LIT11_W-1:0]; // [RULE_05]

  // ----------------------------------------------------------------
  // Decode; masked compare ignores don't-care bits
  // ----------------------------------------------------------------
  function automatic op_t decode(input logic [13:0] w);
    op_t res;
    res = OP_OTHER;
    if ((w & core_exec_pkg::MASK_OR_ACCUM) == core_exec_pkg::PAT_OR_ACCUM)
      res = OP_OR_ACCUM;
    else if ((w & core_exec_pkg::MASK_SKIP_SET) == core_exec_pkg::PAT_SKIP_SET)
      res = OP_SKIP_SET;
    else if ((w & core_exec_pkg::MASK_CALL) == core_exec_pkg::PAT_CALL)
      res = OP_CALL;
    else if ((w & core_exec_pkg::MASK_LOAD_LIT) == core_exec_pkg::PAT_LOAD_LIT)
      res = OP_LOAD_LIT; // [RULE_08]
    return res;
  endfunction

  // Q1: latch the word and its decoded type
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      instr <= 14'h0000;
      op    <= OP_OTHER;
    end
    else if (q1_end)
    begin
      instr <= instr_word; // [RULE_01] [RULE_15]
      op    <= decode(instr_word);
    end
  end

  // ----------------------------------------------------------------
  // Q2 operand read, Q3 processing
  // ----------------------------------------------------------------
  logic [7:0] operand;
  logic [7:0] result;
  logic       skip_taken;
  logic [7:0] next_result;

  assign file_addr = f_field; // [RULE_14]

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      operand <= 8'h00;
    else if (q2_end)
      operand <= (op == OP_LOAD_LIT) ? lit8 : file_rdata; // [RULE_15]
  end

  always_comb
  begin
    next_result = operand;
    unique case (op)
      OP_OR_ACCUM: next_result = accum | operand; // [RULE_11]
      OP_LOAD_LIT: next_result = operand; // [RULE_12]
      OP_SKIP_SET: next_result = operand;
      OP_CALL:     next_result = operand;
      OP_OTHER:    next_result = operand;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      result     <= 8'h00;
      skip_taken <= 1'b0;
    end
    else if (q3_end)
    begin
      result     <= next_result; // [RULE_15]
      skip_taken <= (op == OP_SKIP_SET) && operand[bit_sel]; // [RULE_09] [RULE_04]
    end
  end

  // ----------------------------------------------------------------
  // Q4 writeback, gated in an idle cycle
  // ----------------------------------------------------------------
  wire do_write = cycle_end && !idle_cycle; // [RULE_16]

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      accum <= core_exec_pkg::ACCUM_RESET;
    else if (do_write && (op == OP_LOAD_LIT || (op == OP_OR_ACCUM && !dest_file)))
      accum <= result; // [RULE_02] [RULE_12] [RULE_14]
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      file_we    <= 1'b0;
      file_wdata <= 8'h00;
    end
    else
    begin
      file_we <= do_write && (op == OP_OR_ACCUM) && dest_file; // [RULE_02] [RULE_15]
      if (do_write)
        file_wdata <= result;
    end
  end

  // Only the OR instruction touches a flag, and only zero
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      status_flags <= core_exec_pkg::STATUS_RESET;
    else if (do_write && op == OP_OR_ACCUM)
      status_flags[core_exec_pkg::FLAG_ZERO] <= (result == 8'h00); // [RULE_11] [RULE_13]
  end

  // ----------------------------------------------------------------
  // Program counter, call stack, idle cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      program_counter <= core_exec_pkg::PC_RESET;
      stack_top_entry <= 13'h0000;
      stack_push      <= 1'b0;
    end
    else
    begin
      stack_push <= do_write && (op == OP_CALL);
      if (do_write && op == OP_CALL)
      begin
        stack_top_entry <= program_counter + 13'h0001; // [RULE_10]
        program_counter <= {program_counter_upper_latch[core_exec_pkg::LATCH_HI:
                                                        core_exec_pkg::LATCH_LO],
                            lit11}; // [RULE_10]
      end
      else if (cycle_end)
        program_counter <= program_counter + 13'h0001;
    end
  end

  // Taken skip or call costs a second, idle cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      idle_cycle <= 1'b0;
    else if (cycle_end)
      idle_cycle <= !idle_cycle && (skip_taken || op == OP_CALL); // [RULE_06] [RULE_09]
  end

endmodule

/* testbench/instr_exec_checker.sv */
/* Checker for instr_exec: quarter timing, write gating and instruction results.
   Sees only instr_exec ports; one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module instr_exec_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [13:0] instr_word,
  input wire logic [4:0]  program_counter_upper_latch,
  input wire logic [7:0]  file_rdata,
  input wire logic [6:0]  file_addr,
  input wire logic [7:0]  file_wdata,
  input wire logic        file_we,
  input wire logic [12:0] program_counter,
  input wire logic [12:0] stack_top_entry,
  input wire logic        stack_push,
  input wire logic [7:0]  accum,
  input wire logic [2:0]  status_flags,
  input wire logic        idle_cycle,
  input wire logic [1:0]  quarter,
  input wire logic        cycle_end
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic run;
  logic is_call;
  logic is_lit;
  logic is_or;
  logic is_skip;
  assign run     = cycle_end && !idle_cycle;
  assign is_call = (instr_word & core_exec_pkg::MASK_CALL) == core_exec_pkg::PAT_CALL;
  assign is_lit  = (instr_word & core_exec_pkg::MASK_LOAD_LIT) == core_exec_pkg::PAT_LOAD_LIT;
  assign is_or   = (instr_word & core_exec_pkg::MASK_OR_ACCUM) == core_exec_pkg::PAT_OR_ACCUM;
  assign is_skip = (instr_word & core_exec_pkg::MASK_SKIP_SET) == core_exec_pkg::PAT_SKIP_SET;

  cycle_len_a: assert property (cycle_end |=> !cycle_end [*3] ##1 cycle_end)
    else $error("instruction cycle is not four clocks");
  quarter_end_a: assert property (cycle_end |-> quarter == 2'h3)
    else $error("cycle end outside last quarter");
  quarter_step_a: assert property (quarter != 2'h3 |=> quarter == $past(quarter) + 2'h1)
    else $error("quarter did not advance");
  addr_field_a: assert property (quarter != 2'h0 |-> file_addr == instr_word[6:0])
    else $error("file address not the low seven bits");
  we_source_a: assert property (file_we |-> $past(run) && $past(instr_word[7]))
    else $error("file write without executed destination one");
  idle_quiet_a: assert property (idle_cycle && cycle_end |=>
    !file_we && !stack_push && $stable(accum) && $stable(status_flags))
    else $error("write during idle cycle");
  load_lit_a: assert property (run && is_lit |=>
    accum == $past(instr_word[7:0]) && $stable(status_flags))
    else $error("literal load wrong");
  or_zero_a: assert property (run && is_or && !instr_word[7] |=>
    accum == ($past(accum) | $past(file_rdata)) && status_flags[2] == (accum == 8'h00))
    else $error("or result or zero flag wrong");
  call_load_a: assert property (run && is_call |=> stack_push && idle_cycle &&
    program_counter == {$past(program_counter_upper_latch[4:3]), $past(instr_word[10:0])}
    && stack_top_entry == $past(program_counter) + 13'h0001)
    else $error("call did not load counter and stack");
  pc_step_a: assert property (cycle_end && !(run && is_call) |=>
    program_counter == $past(program_counter) + 13'h0001)
    else $error("counter did not step");
  skip_taken_a: assert property (run && is_skip && file_rdata[instr_word[9:7]] |=>
    idle_cycle)
    else $error("taken skip gave no idle cycle");
endmodule

bind instr_exec instr_exec_checker u_chk (.clk(clk), .reset_n(reset_n),
  .instr_word(instr_word), .program_counter_upper_latch(program_counter_upper_latch),
  .file_rdata(file_rdata), .file_addr(file_addr), .file_wdata(file_wdata),
  .file_we(file_we), .program_counter(program_counter), .stack_top_entry(stack_top_entry),
  .stack_push(stack_push), .accum(accum), .status_flags(status_flags),
  .idle_cycle(idle_cycle), .quarter(quarter), .cycle_end(cycle_end));

/* testbench/tb_top.sv */
/* Self-checking bench for instr_exec: an instruction table, then a mid-run reset.
   Drives every input itself; one instruction every four clocks. */
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("MISMATCH %s expected %h seen %h", n, e, g); \
    end \
  end
module tb_top;
  typedef struct {logic [13:0] w; logic [7:0] rd; logic [7:0] acc; logic z, idle, we;} row_t;
  logic        clk;
  logic        reset_n;
  logic [13:0] instr_word;
  logic [4:0]  latch;
  logic [7:0]  file_rdata;
  logic [6:0]  file_addr;
  logic [7:0]  file_wdata;
  logic        file_we;
  logic [12:0] program_counter;
  logic [12:0] stack_top_entry;
  logic        stack_push;
  logic [7:0]  accum;
  logic [2:0]  status_flags;
  logic        idle_cycle;
  logic [1:0]  quarter;
  logic        cycle_end;
  logic [12:0] pc_exp;
  logic [12:0] stk_exp;
  logic        push_exp;
  row_t        p;
  int          fail_count = 0;
  int          check_count = 0;
  // Word, read data, then accumulator, zero flag, idle next, file write
  row_t rows [15] = '{
    '{14'h305A, 8'h00, 8'h5A, 1'b0, 1'b0, 1'b0}, '{14'h3300, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0},
    '{14'h3091, 8'h00, 8'h91, 1'b0, 1'b0, 1'b0}, '{14'h0413, 8'h13, 8'h93, 1'b0, 1'b0, 1'b0},
    '{14'h3000, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0}, '{14'h04FF, 8'h40, 8'h00, 1'b0, 1'b0, 1'b1},
    '{14'h047F, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0}, '{14'h300F, 8'h00, 8'h0F, 1'b1, 1'b0, 1'b0},
    '{14'h1D85, 8'h08, 8'h0F, 1'b1, 1'b1, 1'b0}, '{14'h30AA, 8'h00, 8'h0F, 1'b1, 1'b0, 1'b0},
    '{14'h1D85, 8'hF7, 8'h0F, 1'b1, 1'b0, 1'b0}, '{14'h30AA, 8'h00, 8'hAA, 1'b1, 1'b0, 1'b0},
    '{14'h2123, 8'h00, 8'hAA, 1'b1, 1'b1, 1'b0}, '{14'h0400, 8'hFF, 8'hAA, 1'b1, 1'b0, 1'b0},
    '{14'h3000, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0}};

  instr_exec u_dut (
    .clk                         (clk),
    .reset_n                     (reset_n),
    .instr_word                  (instr_word),
    .program_counter_upper_latch (latch),
    .file_rdata                  (file_rdata),
    .file_addr                   (file_addr),
    .file_wdata                  (file_wdata),
    .file_we                     (file_we),
    .program_counter             (program_counter),
    .stack_top_entry             (stack_top_entry),
    .stack_push                  (stack_push),
    .accum                       (accum),
    .status_flags                (status_flags),
    .idle_cycle                  (idle_cycle),
    .quarter                     (quarter),
    .cycle_end                   (cycle_end)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Results of the previous row are checked just after its last edge, while pulses stand
  task automatic run(input row_t r);
    instr_word <= r.w;
    file_rdata <= r.rd;
    #1;
    `CHK("accum", p.acc, accum)
    `CHK("flags", {p.z, 2'b00}, status_flags)
    `CHK("idle", p.idle, idle_cycle)
    `CHK("we", p.we, file_we)
    if (p.we) `CHK("wdata", p.rd | p.acc, file_wdata)
    `CHK("push", push_exp, stack_push)
    `CHK("pc", pc_exp, program_counter)
    `CHK("stack", stk_exp, stack_top_entry)
    @(posedge clk);
    #1;
    `CHK("addr", r.w[6:0], file_addr)
    `CHK("quarter", 2'h1, quarter)
    push_exp = 1'b0;
    if ((r.w & core_exec_pkg::MASK_CALL) == core_exec_pkg::PAT_CALL && !p.idle)
    begin
      push_exp = 1'b1;
      stk_exp = pc_exp + 13'h0001;
      pc_exp = {latch[4:3], r.w[10:0]};
    end
    else
      pc_exp = pc_exp + 13'h0001;
    p = r;
    repeat (2) @(posedge clk);
    #1;
    `CHK("cycle end", 1'b1, cycle_end)
    @(posedge clk);
  endtask

  initial
  begin
    #(8 * 300);
    fail_count++;
    complete_run;
  end

  initial
  begin
    reset_n = 1'b0;
    instr_word = 14'h0000;
    file_rdata = 8'h00;
    latch = 5'h1B;
    p = '{14'h0000, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0};
    pc_exp = 13'h0000;
    stk_exp = 13'h0000;
    push_exp = 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i]) run(rows[i]);
    #1;
    `CHK("last accum", p.acc, accum)
    // Reset in mid-instruction, then execute again from a clean state
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("rst accum", core_exec_pkg::ACCUM_RESET, accum)
    `CHK("rst pc", core_exec_pkg::PC_RESET, program_counter)
    `CHK("rst quarter", 2'h0, quarter)
    @(posedge clk);
    reset_n <= 1'b1;
    p = '{14'h0000, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0};
    pc_exp = 13'h0000;
    stk_exp = 13'h0000;
    push_exp = 1'b0;
    run(rows[2]);
    run(rows[3]);
    run(rows[0]);
    #1;
    `CHK("end accum", p.acc, accum)
    complete_run;
  end
endmodule
